// ===== pkg/pbd_pkg.sv
// Shared constants and carrier types of the configuration window bank
package pbd_pkg;

    // Configuration dword offsets (byte addresses)
    localparam logic [7:0] PBD_OFS_MEM = 8'h10;
    localparam logic [7:0] PBD_OFS_IO = 8'h14;
    localparam logic [7:0] PBD_OFS_SDRAM = 8'h18;
    localparam logic [7:0] PBD_OFS_CIS = 8'h28;
    localparam logic [7:0] PBD_OFS_ROM = 8'h30;

    // Reset values
    localparam logic [31:0] PBD_RST_BASE = 32'h0000_0000;
    localparam logic [31:0] PBD_RD_ZERO = 32'h0000_0000;

    // Field positions
    localparam int PBD_MEM_GRP_BIT = 18;
    localparam int PBD_SDRAM_GRP_BIT = 31;
    localparam int PBD_ROM_GRP_BIT = 31;
    localparam int PBD_ROM_EN_BIT = 0;

    // Read-only low fields
    localparam logic [6:0] PBD_MEM_TYPE_PREF = 7'h08;
    localparam logic [6:0] PBD_MEM_TYPE_NONE = 7'h00;
    localparam logic [6:0] PBD_IO_TYPE = 7'h01;
    localparam logic [3:0] PBD_SDRAM_TYPE_PREF = 4'h8;
    localparam logic [3:0] PBD_SDRAM_TYPE_NONE = 4'h0;

    // Fixed never-compared low bits of each window, and the writable bits of the io window
    localparam logic [6:0] PBD_MEM_LOW_IGN = 7'h7f;
    localparam logic [31:0] PBD_IO_IGN = 32'h0000_007f;
    localparam logic [17:0] PBD_SDRAM_LOW_IGN = 18'h3ffff;
    localparam logic [19:0] PBD_ROM_LOW_IGN = 20'hfffff;
    localparam logic [31:0] PBD_IO_WRITABLE = 32'hffff_ff80;

    // Regions inside the control memory window
    localparam logic [31:0] PBD_CSR_LAST = 32'h0000_007c;
    localparam logic [31:0] PBD_ZERO_LAST = 32'h0000_0ffc;

    // Window indices
    localparam int PBD_WIN_MEM = 0;
    localparam int PBD_WIN_IO = 1;
    localparam int PBD_WIN_SDRAM = 2;
    localparam int PBD_WIN_ROM = 3;
    localparam int PBD_NWIN = 4;

    // Configuration access from the PCI target
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] offset;
        logic [3:0] byteEn;
        logic [31:0] data;
    } pbd_cfg_req_t;

    // Masks held by the local processor
    typedef struct packed {
        logic [31:0] mem;
        logic [31:0] sdram;
        logic [31:0] rom;
    } pbd_mask_t;

    // PCI address phase to decode
    typedef struct packed {
        logic valid;
        logic isIo;
        logic [31:0] addr;
    } pbd_acc_t;

    // Decode result
    typedef struct packed {
        logic valid;
        logic ctrlReg;
        logic zeroReg;
        logic sdramViaCtrl;
        logic io;
        logic sdram;
        logic rom;
        logic [31:0] offset;
    } pbd_hit_t;

endpackage

// ===== hw/pbd_win_match.sv
// Address compare of one window against its base
`timescale 1ns/100ps
module pbd_win_match (
    // Access
    input wire logic [31:0] addr,
    input wire logic enable,
    // Window
    input wire logic [31:0] base,
    input wire logic [31:0] ignore,
    // Result
    output logic hit,
    output logic [31:0] offset
);
    wire logic [31:0] diff;

    assign diff = (addr ^ base) & ~ignore;
    assign hit = enable && (diff == 32'h0000_0000);
    assign offset = addr & ignore;
endmodule // pbd_win_match

// ===== hw/pbd_bar_bank.sv
// Configuration window registers and PCI address decode
`timescale 1ns/100ps
module pbd_bar_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration access
    input wire pbd_pkg::pbd_cfg_req_t cfgReq,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    output logic cfgClaim,
    // Masks from the local processor
    input wire pbd_pkg::pbd_mask_t winMask,
    // Command register enables
    input wire logic memSpaceEn,
    input wire logic ioSpaceEn,
    // Address decode
    input wire pbd_pkg::pbd_acc_t pciAcc,
    output pbd_pkg::pbd_hit_t pciHit
);
    import pbd_pkg::*;

    // Byte-lane merge of a configuration write
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wdata,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Stored base values; masked bits are forced to zero on every read, type fields read their fixed codes
    logic [31:0] memBase;
    logic [31:0] ioBase;
    logic [31:0] sdramBase;
    logic [31:0] romBase;
    logic [31:0] next_memBase;
    logic [31:0] next_ioBase;
    logic [31:0] next_sdramBase;
    logic [31:0] next_romBase;

    // Ignored (not compared, read-only except the ROM enable bit) bit sets per window
    wire logic [31:0] memIgn;
    wire logic [31:0] sdramIgn;
    wire logic [31:0] romIgn;
    wire logic [31:0] memWrMask;
    wire logic [31:0] sdramWrMask;
    wire logic [31:0] romWrMask;

    assign memIgn = {4'h0, winMask.mem[27:18], {11{winMask.mem[PBD_MEM_GRP_BIT]}},
                     PBD_MEM_LOW_IGN};
    assign sdramIgn = {{4{winMask.sdram[PBD_SDRAM_GRP_BIT]}}, winMask.sdram[27:18],
                       PBD_SDRAM_LOW_IGN};
    assign romIgn = {{8{winMask.rom[PBD_ROM_GRP_BIT]}}, winMask.rom[23:20], PBD_ROM_LOW_IGN};

    assign memWrMask = ~memIgn;
    assign sdramWrMask = ~sdramIgn;
    assign romWrMask = ~romIgn | {31'h0, ~winMask.rom[PBD_ROM_GRP_BIT]};

    // Write decode
    wire logic wrMem;
    wire logic wrIo;
    wire logic wrSdram;
    wire logic wrRom;

    assign wrMem = cfgReq.wr && (cfgReq.offset == PBD_OFS_MEM);
    assign wrIo = cfgReq.wr && (cfgReq.offset == PBD_OFS_IO);
    assign wrSdram = cfgReq.wr && (cfgReq.offset == PBD_OFS_SDRAM);
    assign wrRom = cfgReq.wr && (cfgReq.offset == PBD_OFS_ROM);

    // Masking on write keeps read-only bits out of storage
    assign next_memBase = wrMem ? (laneMerge(memBase, cfgReq.data, cfgReq.byteEn) & memWrMask)
                                : memBase;
    assign next_ioBase = wrIo ? (laneMerge(ioBase, cfgReq.data, cfgReq.byteEn) & PBD_IO_WRITABLE)
                              : ioBase;
    assign next_sdramBase = wrSdram ? (laneMerge(sdramBase, cfgReq.data, cfgReq.byteEn) & sdramWrMask)
                                    : sdramBase;
    assign next_romBase = wrRom ? (laneMerge(romBase, cfgReq.data, cfgReq.byteEn) & romWrMask)
                                : romBase;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            memBase <= PBD_RST_BASE;
            ioBase <= PBD_RST_BASE;
            sdramBase <= PBD_RST_BASE;
            romBase <= PBD_RST_BASE;
        end else begin
            memBase <= next_memBase;
            ioBase <= next_ioBase;
            sdramBase <= next_sdramBase;
            romBase <= next_romBase;
        end
    end

    // Read values; a mask raised after a write still hides the stored bit
    wire logic [31:0] memRd;
    wire logic [31:0] ioRd;
    wire logic [31:0] sdramRd;
    wire logic [31:0] romRd;
    wire logic [6:0] memType;
    wire logic [3:0] sdramType;

    assign memType = winMask.mem[PBD_MEM_GRP_BIT] ? PBD_MEM_TYPE_NONE : PBD_MEM_TYPE_PREF;
    assign sdramType = winMask.sdram[PBD_SDRAM_GRP_BIT] ? PBD_SDRAM_TYPE_NONE
                                                        : PBD_SDRAM_TYPE_PREF;
    assign memRd = {memBase[31:7] & memWrMask[31:7], memType};
    assign ioRd = {ioBase[31:7], PBD_IO_TYPE};
    assign sdramRd = {sdramBase[31:18] & sdramWrMask[31:18], 14'h0000, sdramType};
    assign romRd = {romBase[31:20] & romWrMask[31:20], 19'h00000,
                    romBase[PBD_ROM_EN_BIT] & romWrMask[PBD_ROM_EN_BIT]};

    wire logic ofsKnown;
    wire logic [31:0] rdMux;

    assign ofsKnown = (cfgReq.offset == PBD_OFS_MEM) || (cfgReq.offset == PBD_OFS_IO)
                      || (cfgReq.offset == PBD_OFS_SDRAM) || (cfgReq.offset == PBD_OFS_CIS)
                      || (cfgReq.offset == PBD_OFS_ROM);
    assign rdMux = (cfgReq.offset == PBD_OFS_MEM) ? memRd :
                   (cfgReq.offset == PBD_OFS_IO) ? ioRd :
                   (cfgReq.offset == PBD_OFS_SDRAM) ? sdramRd :
                   (cfgReq.offset == PBD_OFS_ROM) ? romRd :
                   PBD_RD_ZERO;

    // One cycle read answer; the data stands until the next read
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfgRdData <= PBD_RD_ZERO;
            cfgRdValid <= 1'b0;
            cfgClaim <= 1'b0;
        end else begin
            cfgRdValid <= cfgReq.rd;
            cfgClaim <= (cfgReq.rd || cfgReq.wr) && ofsKnown;
            if (cfgReq.rd) begin
                cfgRdData <= rdMux;
            end
        end
    end

    // Window compare, one instance per window
    logic [31:0] winBase [PBD_NWIN];
    logic [31:0] winIgn [PBD_NWIN];
    logic winEn [PBD_NWIN];
    logic winHit [PBD_NWIN];
    logic [31:0] winOfs [PBD_NWIN];

    // An all-masked SDRAM or ROM window would match everything, so it is closed
    assign winBase[PBD_WIN_MEM] = memBase;
    assign winIgn[PBD_WIN_MEM] = memIgn;
    assign winEn[PBD_WIN_MEM] = pciAcc.valid && !pciAcc.isIo && memSpaceEn;
    assign winBase[PBD_WIN_IO] = ioBase;
    assign winIgn[PBD_WIN_IO] = PBD_IO_IGN;
    assign winEn[PBD_WIN_IO] = pciAcc.valid && pciAcc.isIo && ioSpaceEn;
    assign winBase[PBD_WIN_SDRAM] = sdramBase;
    assign winIgn[PBD_WIN_SDRAM] = sdramIgn;
    assign winEn[PBD_WIN_SDRAM] = pciAcc.valid && !pciAcc.isIo && memSpaceEn
                                  && !winMask.sdram[PBD_SDRAM_GRP_BIT];
    assign winBase[PBD_WIN_ROM] = romBase;
    assign winIgn[PBD_WIN_ROM] = romIgn;
    assign winEn[PBD_WIN_ROM] = pciAcc.valid && !pciAcc.isIo && memSpaceEn
                                && romRd[PBD_ROM_EN_BIT];

    genvar w;
    generate
        for (w = 0; w < PBD_NWIN; w++) begin : g_win
            pbd_win_match u_match (
                .addr(pciAcc.addr),
                .enable(winEn[w]),
                .base(winBase[w]),
                .ignore(winIgn[w]),
                .hit(winHit[w]),
                .offset(winOfs[w])
            );
        end
    endgenerate

    // Region split of the control memory window
    wire logic [31:0] memOfs;
    wire logic inCsr;
    wire logic inZero;
    pbd_hit_t next_pciHit;

    assign memOfs = winOfs[PBD_WIN_MEM];
    assign inCsr = memOfs <= PBD_CSR_LAST;
    assign inZero = !inCsr && (memOfs <= PBD_ZERO_LAST);
    assign next_pciHit.valid = pciAcc.valid;
    assign next_pciHit.ctrlReg = winHit[PBD_WIN_MEM] && inCsr;
    assign next_pciHit.zeroReg = winHit[PBD_WIN_MEM] && inZero;
    assign next_pciHit.sdramViaCtrl = winHit[PBD_WIN_MEM] && !inCsr && !inZero;
    assign next_pciHit.io = winHit[PBD_WIN_IO];
    assign next_pciHit.sdram = winHit[PBD_WIN_SDRAM];
    assign next_pciHit.rom = winHit[PBD_WIN_ROM];
    assign next_pciHit.offset = winHit[PBD_WIN_MEM] ? memOfs :
                                winHit[PBD_WIN_IO] ? winOfs[PBD_WIN_IO] :
                                winHit[PBD_WIN_SDRAM] ? winOfs[PBD_WIN_SDRAM] :
                                winHit[PBD_WIN_ROM] ? winOfs[PBD_WIN_ROM] : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pciHit <= '0;
        end else begin
            pciHit <= next_pciHit;
        end
    end

    // Checks
    logic [7:0] rdOfsQ;
    logic [31:0] memIgnQ;
    logic [31:0] sdramIgnQ;
    logic memGrpQ;
    logic sdramGrpQ;
    logic romGrpQ;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdOfsQ <= 8'h00;
            memIgnQ <= 32'h0000_0000;
            sdramIgnQ <= 32'h0000_0000;
            memGrpQ <= 1'b0;
            sdramGrpQ <= 1'b0;
            romGrpQ <= 1'b0;
        end else begin
            rdOfsQ <= cfgReq.offset;
            memIgnQ <= memIgn;
            sdramIgnQ <= sdramIgn;
            memGrpQ <= winMask.mem[PBD_MEM_GRP_BIT];
            sdramGrpQ <= winMask.sdram[PBD_SDRAM_GRP_BIT];
            romGrpQ <= winMask.rom[PBD_ROM_GRP_BIT];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    read_latency_a: assert property (cfgReq.rd |=> cfgRdValid)
        else $error("read answer missing");
    mem_type_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_MEM
        |-> cfgRdData[6:0] == (memGrpQ ? PBD_MEM_TYPE_NONE : PBD_MEM_TYPE_PREF))
        else $error("memory window type field wrong");
    mem_ro_zero_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_MEM
        |-> ((cfgRdData & memIgnQ) >> 7) == 32'h0)
        else $error("masked memory window bit reads nonzero");
    io_low_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_IO |-> cfgRdData[6:0] == PBD_IO_TYPE)
        else $error("io window low field wrong");
    sdram_type_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_SDRAM
        |-> cfgRdData[3:0] == (sdramGrpQ ? PBD_SDRAM_TYPE_NONE : PBD_SDRAM_TYPE_PREF)
            && cfgRdData[17:4] == 14'h0000 && (cfgRdData[31:18] & sdramIgnQ[31:18]) == 14'h0000)
        else $error("sdram window read wrong");
    rom_middle_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_ROM |-> cfgRdData[19:1] == 19'h00000)
        else $error("rom window middle bits nonzero");
    cis_zero_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_CIS |-> cfgRdData == PBD_RD_ZERO)
        else $error("card info pointer nonzero");
    io_write_a: assert property (cfgReq.wr && cfgReq.offset == PBD_OFS_IO && cfgReq.byteEn == 4'hf
        |=> ioBase[31:7] == $past(cfgReq.data[31:7]))
        else $error("io window write lost");
    mem_top_write_a: assert property (cfgReq.wr && cfgReq.offset == PBD_OFS_MEM && cfgReq.byteEn[3]
        ##1 cfgReq.rd && cfgReq.offset == PBD_OFS_MEM && !cfgReq.wr
        |=> cfgRdData[31:28] == $past(cfgReq.data[31:28], 2))
        else $error("memory window top bits not writable");
    decode_latency_a: assert property (pciAcc.valid |=> pciHit.valid)
        else $error("decode answer missing");
    region_excl_a: assert property (pciHit.valid
        |-> $onehot0({pciHit.ctrlReg, pciHit.zeroReg, pciHit.sdramViaCtrl}))
        else $error("memory window regions overlap");
    rom_enable_a: assert property (pciHit.rom |-> $past(romBase[PBD_ROM_EN_BIT]))
        else $error("rom hit while decode disabled");

    // Read-only bits must never reach storage, else a later mask change exposes them
    mem_ro_store_a: assert property (wrMem |=> (memBase & $past(memIgn)) == 32'h0000_0000)
        else $error("masked memory window bit stored");
    sdram_ro_store_a: assert property (wrSdram |=> (sdramBase & $past(sdramIgn)) == 32'h0000_0000)
        else $error("masked sdram window bit stored");
    rom_ro_store_a: assert property (wrRom |=> (romBase & ~$past(romWrMask)) == 32'h0000_0000)
        else $error("masked rom window bit stored");
    io_ro_store_a: assert property (wrIo |=> ioBase[6:0] == 7'h00)
        else $error("io window low bits stored");
    reset_bases_a: assert property ($past(sys_rst) |-> memBase == PBD_RST_BASE && ioBase == PBD_RST_BASE
        && sdramBase == PBD_RST_BASE && romBase == PBD_RST_BASE)
        else $error("window base not cleared by reset");

    // Read side, checked against the mask as it stood when the read was taken
    mem_group_rd_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_MEM && memGrpQ
        |-> cfgRdData[17:7] == 11'h000)
        else $error("memory window group bits not hidden");
    mem_top_rd_a: assert property (cfgReq.rd && cfgReq.offset == PBD_OFS_MEM
        |=> cfgRdData[31:28] == $past(memBase[31:28]))
        else $error("memory window top bits hidden");
    io_read_a: assert property (cfgReq.rd && cfgReq.offset == PBD_OFS_IO
        |=> cfgRdData[31:7] == $past(ioBase[31:7]))
        else $error("io window base read wrong");
    sdram_top_rd_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_SDRAM && sdramGrpQ
        |-> cfgRdData[31:28] == 4'h0)
        else $error("sdram window top bits not hidden");
    rom_hidden_a: assert property (cfgRdValid && rdOfsQ == PBD_OFS_ROM && romGrpQ
        |-> cfgRdData[31:24] == 8'h00 && !cfgRdData[PBD_ROM_EN_BIT])
        else $error("rom window group bits not hidden");
    cis_claim_a: assert property ((cfgReq.rd || cfgReq.wr) && cfgReq.offset == PBD_OFS_CIS
        |=> cfgClaim)
        else $error("card info pointer access not claimed");

    // Decode side
    hit_idle_a: assert property (!pciHit.valid |-> pciHit == '0)
        else $error("decode flags raised without an access");
    io_hit_a: assert property (pciHit.io
        |-> $past(pciAcc.isIo && ioSpaceEn) && pciHit.offset[31:7] == 25'h0)
        else $error("io hit outside io space or region");
    sdram_closed_a: assert property (pciHit.sdram
        |-> $past(!winMask.sdram[PBD_SDRAM_GRP_BIT] && memSpaceEn))
        else $error("sdram hit while window closed");
    rom_closed_a: assert property (pciHit.rom |-> $past(!winMask.rom[PBD_ROM_GRP_BIT]))
        else $error("rom hit while its group is masked");
    csr_range_a: assert property (pciHit.ctrlReg |-> pciHit.offset <= PBD_CSR_LAST)
        else $error("control register hit beyond its range");
    zero_range_a: assert property (pciHit.zeroReg |-> pciHit.offset > PBD_CSR_LAST && pciHit.offset <= PBD_ZERO_LAST)
        else $error("zero region hit outside its range");
    sdram_range_a: assert property (pciHit.sdramViaCtrl |-> pciHit.offset > PBD_ZERO_LAST)
        else $error("sdram region hit below its range");

    csr_hit_c: cover property (pciHit.ctrlReg);
    sdram_via_ctrl_c: cover property (pciHit.sdramViaCtrl);
    rom_hit_c: cover property (pciHit.rom);
    io_hit_c: cover property (pciHit.io);
    zero_region_c: cover property (pciHit.zeroReg);
endmodule // pbd_bar_bank

// ===== verif/pbd_host_model.sv
// Host side model issuing configuration cycles and address phases
`timescale 1ns/100ps
module pbd_host_model (
    // Clock
    input wire logic mclk,
    // Requests toward the bank
    output pbd_pkg::pbd_cfg_req_t cfgReq,
    output pbd_pkg::pbd_acc_t pciAcc
);
    import pbd_pkg::*;

    initial begin
        cfgReq = '0;
        pciAcc = '0;
    end

    // One request per edge, held until the taking edge
    // Each task drops the other strobe so a held request is never taken twice
    task automatic cfgCycle(input pbd_cfg_req_t req);
        cfgReq <= req;
        pciAcc.valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic accCycle(input pbd_acc_t acc);
        pciAcc <= acc;
        cfgReq.rd <= 1'b0;
        cfgReq.wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Released lines toggle so a stale value is never mistaken for data
    task automatic idle();
        cfgReq <= '{1'b0, 1'b0, ~cfgReq.offset, ~cfgReq.byteEn, ~cfgReq.data};
        pciAcc <= '{1'b0, ~pciAcc.isIo, ~pciAcc.addr};
        @(posedge mclk);
    endtask
endmodule // pbd_host_model

// ===== verif/pbd_bar_bank_tb_top.sv
// Self-checking bench of the configuration window bank
`timescale 1ns/100ps
module pbd_bar_bank_tb_top;
    import pbd_pkg::*;
    logic mclk;
    logic sys_rst;
    pbd_cfg_req_t cfgReq;
    logic [31:0] cfgRdData;
    logic cfgRdValid;
    logic cfgClaim;
    pbd_mask_t winMask;
    logic memSpaceEn;
    logic ioSpaceEn;
    pbd_acc_t pciAcc;
    pbd_hit_t pciHit;
    int mismatches;
    int tests_run;
    int seed;
    logic [31:0] shadow [4];
    logic [31:0] rdQ [$];
    logic [39:0] hitQ [$];
    logic [39:0] e;
    logic claimExp;
    logic [7:0] ofsList [6] = '{PBD_OFS_MEM, PBD_OFS_IO, PBD_OFS_SDRAM, PBD_OFS_CIS, PBD_OFS_ROM, 8'h1c};

    pbd_host_model i_pbd_host_model (.mclk(mclk), .cfgReq(cfgReq), .pciAcc(pciAcc));
    pbd_bar_bank i_pbd_bar_bank (.mclk(mclk), .sys_rst(sys_rst), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .cfgClaim(cfgClaim), .winMask(winMask), .memSpaceEn(memSpaceEn),
        .ioSpaceEn(ioSpaceEn), .pciAcc(pciAcc), .pciHit(pciHit));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic int winOf(input logic [7:0] ofs);
        case (ofs)
            PBD_OFS_MEM: return PBD_WIN_MEM;
            PBD_OFS_IO: return PBD_WIN_IO;
            PBD_OFS_SDRAM: return PBD_WIN_SDRAM;
            PBD_OFS_ROM: return PBD_WIN_ROM;
            default: return -1;
        endcase
    endfunction

    function automatic logic [31:0] wrMask(input int w);
        case (w)
            0: return {4'hf, ~winMask.mem[27:18], {11{~winMask.mem[18]}}, 7'h00};
            1: return 32'hffff_ff80;
            2: return {{4{~winMask.sdram[31]}}, ~winMask.sdram[27:18], 18'h0};
            default: return {{8{~winMask.rom[31]}}, ~winMask.rom[23:20], 19'h0, ~winMask.rom[31]};
        endcase
    endfunction

    function automatic logic [31:0] readVal(input int w);
        logic [31:0] t;
        t = 32'h0;
        if (w == 0) t = winMask.mem[18] ? 32'h0 : 32'h8;
        if (w == 1) t = 32'h1;
        if (w == 2) t = winMask.sdram[31] ? 32'h0 : 32'h8;
        return w < 0 ? 32'h0 : (shadow[w] & wrMask(w)) | t;
    endfunction

    // ROM compare never looks below its 1 MB boundary
    function automatic logic [31:0] ign(input int w);
        return ~wrMask(w) | (w == 3 ? 32'hfffff : 32'h0);
    endfunction

    function automatic logic hitOf(input int w, input logic [31:0] a);
        return ((a ^ readVal(w)) & ~ign(w)) == 32'h0;
    endfunction

    task automatic cfgOp(input logic rd, input logic wr, input logic [7:0] ofs, input logic [3:0] be,
                         input logic [31:0] d);
        logic [31:0] bm;
        int w;
        w = winOf(ofs);
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (rd) rdQ.push_back(readVal(w));
        if (wr && w >= 0) shadow[w] = ((shadow[w] & ~bm) | (d & bm)) & wrMask(w);
        i_pbd_host_model.cfgCycle('{rd, wr, ofs, be, d});
    endtask

    task automatic accOp(input logic io, input logic [31:0] a);
        logic [3:0] h;
        logic [31:0] o;
        logic [31:0] m;
        h[0] = memSpaceEn & !io & hitOf(0, a);
        h[1] = ioSpaceEn & io & hitOf(1, a);
        h[2] = memSpaceEn & !io & !winMask.sdram[31] & hitOf(2, a);
        h[3] = memSpaceEn & !io & shadow[3][0] & !winMask.rom[31] & hitOf(3, a);
        m = a & ign(0);
        o = h[0] ? m : h[1] ? a & ign(1) : h[2] ? a & ign(2) : a & ign(3);
        hitQ.push_back({|h, 1'b1, h[0] && m <= 32'h7c, h[0] && m > 32'h7c && m <= 32'hffc,
                        h[0] && m > 32'hffc, h[1], h[2], h[3], o});
        i_pbd_host_model.accCycle('{1'b1, io, a});
    endtask

    always @(posedge mclk) begin
        if (!sys_rst) begin
            check({31'h0, cfgClaim}, {31'h0, claimExp});
            if (cfgRdValid === 1'b1) begin
                check(cfgRdData, rdQ.size() > 0 ? rdQ.pop_front() : 32'hdead_beef);
            end
            if (pciHit.valid === 1'b1) begin
                e = hitQ.size() > 0 ? hitQ.pop_front() : '1;
                check({25'h0, pciHit[38:32]}, {25'h0, e[38:32]});
                if (e[39]) check(pciHit.offset, e[31:0]);
            end
        end
        claimExp <= (cfgReq.rd | cfgReq.wr) & (winOf(cfgReq.offset) >= 0 || cfgReq.offset == PBD_OFS_CIS);
    end

    initial begin
        int ph;
        int k;
        int w;
        logic [31:0] r;
        pbd_mask_t mk;
        seed = 32'h559784bc;
        mismatches = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        winMask = '0;
        memSpaceEn = 1'b0;
        ioSpaceEn = 1'b0;
        foreach (shadow[i]) shadow[i] = 32'h0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        foreach (ofsList[i]) cfgOp(1'b1, 1'b0, ofsList[i], 4'hf, 32'h0);
        for (ph = 0; ph < 8; ph++) begin
            mk = {$random(seed), $random(seed), $random(seed)};
            mk.mem[18] = ph[0];
            mk.sdram[31] = ph[1];
            mk.rom[31] = ph[2];
            // Masks settle before any host access of the phase
            winMask <= mk;
            memSpaceEn <= (ph != 5);
            ioSpaceEn <= (ph != 6);
            i_pbd_host_model.idle();
            for (w = 0; w < 6; w++) cfgOp(1'b0, 1'b1, ofsList[w], 4'hf, $random(seed));
            for (k = 0; k < 6; k++) begin
                r = $random(seed);
                cfgOp(r[0], 1'b1, ofsList[r[6:4] % 6], r[11:8], $random(seed));
            end
            cfgOp(1'b0, 1'b1, PBD_OFS_MEM, 4'h8, $random(seed));
            foreach (ofsList[i]) cfgOp(1'b1, 1'b0, ofsList[i], 4'hf, 32'h0);
            for (k = 0; k < 16; k++) begin
                r = $random(seed);
                w = r[1:0];
                m_sel: begin
                    logic [31:0] lim;
                    lim = r[6:5] == 0 ? 32'h7c : r[6:5] == 1 ? 32'hffc : 32'hffff_ffff;
                    if (r[3:2] == 0) accOp(r[4], $random(seed) & ~32'h3);
                    else accOp(w == 1, ((readVal(w) & ~ign(w)) | ($random(seed) & ign(w) & lim)) & ~32'h3);
                end
            end
            i_pbd_host_model.idle();
        end
        repeat (4) @(posedge mclk);
        check(rdQ.size() + hitQ.size(), 32'h0);
        end_sim();
    end

    // Whole run is a few hundred cycles
    initial begin
        repeat (4000) @(posedge mclk);
        mismatches++;
        end_sim();
    end
endmodule // pbd_bar_bank_tb_top
